/* shared/gwt_pkg.sv */
/*
 * gwt_pkg: constants, register indices and carrier types for the
 * guarded watchdog timer.
 * assumes: a single 125 MHz clock domain and an AHB-Lite register bus
 * with 32-bit data, one register per aligned word.
 */
`default_nettype none

package gwt_pkg;

   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int unsigned REF_CLK_PERIOD_PS = 8000;   // 125 MHz
   localparam int unsigned SYS_DIV           = 8192;   // system clock divider
   localparam int unsigned WATCH_DIV         = 32;     // watch clock divider
   localparam int unsigned RST_HOLD_OSC      = 512;    // reset length, osc cycles
   // the oscillator clock is ref_clk itself, so one osc cycle is one cycle
   localparam int unsigned RST_HOLD_CYC      = RST_HOLD_OSC * 8000 / REF_CLK_PERIOD_PS;

   // ----------------------------------------------------------------
   // register indices (byte address = 4 * index)
   // ----------------------------------------------------------------
   localparam logic [15:0] IDX_CTRL_STATUS  = 16'hffb2;  // watchdog_control_status
   localparam logic [15:0] IDX_COUNTER      = 16'hffb3;  // watchdog_counter
   localparam logic [15:0] IDX_PORT_SEL_TWO = 16'hffc9;  // port_function_select_two
   localparam logic [15:0] IDX_CLK_STOP_TWO = 16'hfffb;  // module_clock_stop_two
   localparam logic [15:0] IDX_IRQ_STATUS   = 16'h0100;  // sticky event bits
   localparam logic [15:0] IDX_IRQ_MASK     = 16'h0101;  // interrupt mask

   // ----------------------------------------------------------------
   // reset values and field positions
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_STATUS_RST  = 8'haa;
   localparam logic [7:0] COUNTER_RST      = 8'h00;
   localparam logic [7:0] PORT_SEL_RST     = 8'hd8;
   localparam logic [7:0] CLK_STOP_RST     = 8'hff;
   localparam logic [7:0] PORT_SEL_RW_MASK = 8'h27;  // bits 5,2,1,0 writable
   localparam logic [7:0] CLK_STOP_RW_MASK = 8'h1f;  // bits 4..0 writable
   localparam logic [7:0] COUNTER_MAX      = 8'hff;

   localparam int unsigned BIT_CWE_INH  = 7;  // counter_enable_write_inhibit
   localparam int unsigned BIT_CWE      = 6;  // counter_write_enable
   localparam int unsigned BIT_CRWE_INH = 5;  // register_enable_write_inhibit
   localparam int unsigned BIT_CRWE     = 4;  // control_register_write_enable
   localparam int unsigned BIT_RUN_INH  = 3;  // run_enable_write_inhibit
   localparam int unsigned BIT_RUN      = 2;  // run_enable
   localparam int unsigned BIT_FLAG_INH = 1;  // reset_flag_write_inhibit
   localparam int unsigned BIT_FLAG     = 0;  // overflow_reset_flag
   localparam int unsigned BIT_CLK_SEL  = 2;  // watchdog_clock_select
   localparam int unsigned BIT_MOD_STOP = 2;  // watchdog_module_stop

   localparam int unsigned IRQ_W        = 2;
   localparam int unsigned EVT_OVERFLOW = 0;  // counter overflowed
   localparam int unsigned EVT_REFUSED  = 1;  // counter write refused

   // ----------------------------------------------------------------
   // ahb constants
   // ----------------------------------------------------------------
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
   localparam logic       HRESP_OKAY    = 1'b0;

   // ----------------------------------------------------------------
   // carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic counter_write_enable;
      logic control_register_write_enable;
      logic run_enable;
      logic overflow_reset_flag;
   } gwt_ctrl_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [15:0] index;
   } gwt_addr_phase_t;

   typedef enum logic [1:0] {
      GWT_ST_COUNT = 2'b01,   // normal operation
      GWT_ST_RESET = 2'b10    // internal reset being held
   } gwt_state_t;

endpackage

`default_nettype wire

/* hw/gwt_watchdog.sv */
/*
 * gwt_watchdog: guarded watchdog timer with an AHB-Lite register slave.
 * assumes: ref_clk is also the oscillator clock; watch_clk is a slow level
 * synchronous to ref_clk; the bus master issues single word transfers.
 */
// Register access over AHB-Lite was decided locally.
// Function
// (R1) eight-bit up-counter, one step per tick
// (R2) tick: system clock /8192 or watch /32
// (R3) counter overflow raises internal chip reset
// (R4) start value loaded sets period 1..256
// (R5) module standby halts the watchdog
// (R6) control resets to aa, inhibit bits read 1
// (R7) counter write enable changes only with bit7 zero
// (R8) counter writes only while counter write enable set
// (R9) register write enable changes only with bit5 zero
// (R10) run and flag writable only with register enable
// (R11) run write also needs bit3 zero
// (R12) guarded write of one sets run enable
// (R13) run clears on reset or guarded zero write
// (R14) counting follows run enable
// (R15) flag write needs bit1 zero
// (R16) flag set by overflow, cleared by pin/software
// (R17) overflow after ff, reset one cycle later, 512 long
// (R18) clock select zero picks system divider
// (R19) standby only takes effect while run is clear
`timescale 1ns/1ps
`default_nettype none

module gwt_watchdog
   import gwt_pkg::*;
#(
   parameter int unsigned SYS_DIVIDER   = SYS_DIV,      // system clock divider
   parameter int unsigned WATCH_DIVIDER = WATCH_DIV,    // watch clock divider
   parameter int unsigned RESET_HOLD    = RST_HOLD_CYC  // reset length in cycles
)
(
   input  wire  logic        ref_clk,
   input  wire  logic        rst_n,
   input  wire  logic        clk_en,
   input  wire  logic        watch_clk,
   input  wire  logic        hsel,
   input  wire  logic [31:0] haddr,
   input  wire  logic [1:0]  htrans,
   input  wire  logic        hwrite,
   input  wire  logic [2:0]  hsize,
   input  wire  logic [31:0] hwdata,
   input  wire  logic        hready,
   output logic        [31:0] hrdata,
   output logic              hreadyout,
   output logic              hresp,
   output logic              chip_reset_req,
   output logic              irq
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   gwt_ctrl_t       ctrl_r;          // guarded control bits
   logic [7:0]      counter_r;       // watchdog counter
   logic [7:0]      port_sel_r;      // port function select register
   logic [7:0]      clk_stop_r;      // module clock stop register
   logic [IRQ_W-1:0] irq_status_r;   // sticky events
   logic [IRQ_W-1:0] irq_mask_r;     // interrupt enables
   gwt_addr_phase_t aph_r;           // latched address phase
   logic            rd_pend_r;       // read waiting for its data cycle
   logic [12:0]     sys_div_r;       // system clock prescaler
   logic [4:0]      watch_div_r;     // watch clock edge counter
   logic            watch_prev_r;    // watch clock level one cycle ago
   logic            ovf_pend_r;      // overflow seen, reset next cycle
   logic [9:0]      hold_r;          // reset hold countdown
   gwt_state_t      state_r;         // count or reset-hold
   gwt_state_t      state_nxt;
   logic [31:0]     hrdata_r;
   logic            hreadyout_r;
   logic            chip_reset_r;
   logic            irq_r;
   logic [IRQ_W-1:0] irq_status_nxt;

   logic            wr_now;          // write data phase completes now
   logic [7:0]      wd;              // written byte
   logic            standby;         // module standby in force
   logic            active;          // prescalers and counter may move
   logic            tick;            // one counter step
   logic            ovf;             // counter overflows on this tick
   logic            cnt_wr_ok;       // accepted counter write
   logic            cnt_wr_bad;      // refused counter write
   logic            in_reset;        // internal reset being held

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // true when a write in its data phase targets the given index
   function automatic logic hit(input gwt_addr_phase_t a, input logic [15:0] idx);
      hit = a.valid && a.write && (a.index == idx);
   endfunction

   // ----------------------------------------------------------------
   // combinational decode
   // ----------------------------------------------------------------
   always_comb
   begin
      wr_now     = aph_r.valid && aph_r.write;
      wd         = hwdata[7:0];
      // standby request is held off while the watchdog is running
      standby    = !clk_stop_r[BIT_MOD_STOP] && !ctrl_r.run_enable;  // R19 R5
      in_reset   = (state_r == GWT_ST_RESET);
      active     = ctrl_r.run_enable && !standby && !in_reset;       // R14
      // clock select: 0 picks the system divider, 1 the watch divider
      if (!port_sel_r[BIT_CLK_SEL])                                   // R18
      begin
         tick = active && (sys_div_r == 13'(SYS_DIVIDER - 1));        // R2
      end
      else
      begin
         tick = active && watch_clk && !watch_prev_r
                && (watch_div_r == 5'(WATCH_DIVIDER - 1));            // R2
      end
      ovf        = tick && (counter_r == COUNTER_MAX);                // R17
      cnt_wr_ok  = hit(aph_r, IDX_COUNTER) && ctrl_r.counter_write_enable;   // R8
      cnt_wr_bad = hit(aph_r, IDX_COUNTER) && !ctrl_r.counter_write_enable;  // R8
   end

   // ----------------------------------------------------------------
   // ahb address phase capture and response timing
   // ----------------------------------------------------------------
   // writes take no wait state; reads take one so that a write just
   // before is already visible in the read data
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         aph_r       <= '0;
         rd_pend_r   <= 1'b0;
         hreadyout_r <= 1'b1;
      end
      else if (clk_en)
      begin
         if (hready && hreadyout_r)
         begin
            // new address phase accepted
            aph_r.valid <= hsel && (htrans == HTRANS_NONSEQ);
            aph_r.write <= hwrite;
            aph_r.index <= haddr[17:2];
            if (hsel && (htrans == HTRANS_NONSEQ) && !hwrite)
            begin
               rd_pend_r   <= 1'b1;
               hreadyout_r <= 1'b0;
            end
         end
         else if (rd_pend_r)
         begin
            // wait state ends, read data presented
            rd_pend_r   <= 1'b0;
            hreadyout_r <= 1'b1;
            aph_r.valid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // read data mux
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         hrdata_r <= 32'h0000_0000;
      end
      else if (clk_en && rd_pend_r)
      begin
         case (aph_r.index)
            // inhibit bits always read as one
            IDX_CTRL_STATUS:                                          // R6
               hrdata_r <= {24'h00_0000, 1'b1, ctrl_r.counter_write_enable,
                            1'b1, ctrl_r.control_register_write_enable,
                            1'b1, ctrl_r.run_enable,
                            1'b1, ctrl_r.overflow_reset_flag};
            IDX_COUNTER:      hrdata_r <= {24'h00_0000, counter_r};
            IDX_PORT_SEL_TWO: hrdata_r <= {24'h00_0000, port_sel_r};
            IDX_CLK_STOP_TWO: hrdata_r <= {24'h00_0000, clk_stop_r};
            IDX_IRQ_STATUS:   hrdata_r <= {30'h0000_0000, irq_status_r};
            IDX_IRQ_MASK:     hrdata_r <= {30'h0000_0000, irq_mask_r};
            // unmapped reads return zero
            default:          hrdata_r <= 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // guarded control bits
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         // pin reset: all guarded bits to their initial values
         ctrl_r <= '{counter_write_enable:          CTRL_STATUS_RST[BIT_CWE],
                     control_register_write_enable: CTRL_STATUS_RST[BIT_CRWE],
                     run_enable:                    CTRL_STATUS_RST[BIT_RUN],
                     overflow_reset_flag:           CTRL_STATUS_RST[BIT_FLAG]}; // R6 R13 R16
      end
      else if (clk_en)
      begin
         if (in_reset)
         begin
            // the internal chip reset returns the enables to reset state
            ctrl_r.counter_write_enable          <= CTRL_STATUS_RST[BIT_CWE];
            ctrl_r.control_register_write_enable <= CTRL_STATUS_RST[BIT_CRWE];
            ctrl_r.run_enable                    <= CTRL_STATUS_RST[BIT_RUN]; // R13
         end
         else if (hit(aph_r, IDX_CTRL_STATUS))
         begin
            // counter write enable changes only with its inhibit at zero
            if (!wd[BIT_CWE_INH])                                     // R7
            begin
               ctrl_r.counter_write_enable <= wd[BIT_CWE];
            end
            // register write enable changes only with its inhibit at zero
            if (!wd[BIT_CRWE_INH])                                    // R9
            begin
               ctrl_r.control_register_write_enable <= wd[BIT_CRWE];
            end
            // run enable: needs the current register enable and bit 3 zero
            if (ctrl_r.control_register_write_enable && !wd[BIT_RUN_INH]) // R10 R11
            begin
               ctrl_r.run_enable <= wd[BIT_RUN];                      // R12 R13
            end
         end
         // reset flag: overflow sets it and wins over a clear
         if (ovf_pend_r)
         begin
            ctrl_r.overflow_reset_flag <= 1'b1;                       // R16
         end
         else if (hit(aph_r, IDX_CTRL_STATUS) && !in_reset
                  && ctrl_r.control_register_write_enable
                  && !wd[BIT_FLAG_INH])                               // R10 R15
         begin
            ctrl_r.overflow_reset_flag <= wd[BIT_FLAG];               // R16
         end
      end
   end

   // ----------------------------------------------------------------
   // prescalers for both tick sources
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         sys_div_r    <= 13'h0000;
         watch_div_r  <= 5'h00;
         watch_prev_r <= 1'b0;
      end
      else if (clk_en)
      begin
         watch_prev_r <= watch_clk;
         if (!active)
         begin
            // halted: prescalers hold, as in module standby
            sys_div_r   <= sys_div_r;                                 // R5
            watch_div_r <= watch_div_r;
         end
         else if (!port_sel_r[BIT_CLK_SEL])
         begin
            sys_div_r <= (sys_div_r == 13'(SYS_DIVIDER - 1)) ? 13'h0000
                         : sys_div_r + 13'h0001;                       // R2
         end
         else if (watch_clk && !watch_prev_r)
         begin
            watch_div_r <= (watch_div_r == 5'(WATCH_DIVIDER - 1)) ? 5'h00
                           : watch_div_r + 5'h01;                      // R2
         end
      end
   end

   // ----------------------------------------------------------------
   // watchdog counter
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         counter_r <= COUNTER_RST;
      end
      else if (clk_en)
      begin
         if (in_reset)
         begin
            counter_r <= COUNTER_RST;
         end
         else if (cnt_wr_ok)
         begin
            // loaded start value; a write beats a tick in the same cycle
            counter_r <= wd;                                          // R4 R8
         end
         else if (tick)
         begin
            counter_r <= counter_r + 8'h01;                           // R1
         end
      end
   end

   // ----------------------------------------------------------------
   // overflow to internal reset sequencing
   // ----------------------------------------------------------------
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         GWT_ST_COUNT:
         begin
            // reset issued one cycle after the overflow tick
            if (ovf_pend_r)
            begin
               state_nxt = GWT_ST_RESET;                              // R17
            end
         end
         GWT_ST_RESET:
         begin
            if (hold_r == 10'h001)
            begin
               state_nxt = GWT_ST_COUNT;
            end
         end
         default: state_nxt = GWT_ST_COUNT;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         state_r      <= GWT_ST_COUNT;
         ovf_pend_r   <= 1'b0;
         hold_r       <= 10'h000;
         chip_reset_r <= 1'b0;
      end
      else if (clk_en)
      begin
         state_r    <= state_nxt;
         ovf_pend_r <= ovf;                                           // R3 R17
         if (state_r == GWT_ST_COUNT && ovf_pend_r)
         begin
            hold_r       <= 10'(RESET_HOLD);                          // R17
            chip_reset_r <= 1'b1;                                     // R3
         end
         else if (state_r == GWT_ST_RESET)
         begin
            hold_r       <= hold_r - 10'h001;
            chip_reset_r <= (hold_r != 10'h001);                      // R17
         end
      end
   end

   // ----------------------------------------------------------------
   // plain registers: clock select and module stop
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         port_sel_r <= PORT_SEL_RST;                                  // R18
         clk_stop_r <= CLK_STOP_RST;
      end
      else if (clk_en)
      begin
         if (hit(aph_r, IDX_PORT_SEL_TWO))
         begin
            port_sel_r <= (wd & PORT_SEL_RW_MASK) | (PORT_SEL_RST & ~PORT_SEL_RW_MASK);
         end
         if (hit(aph_r, IDX_CLK_STOP_TWO))
         begin
            // bit stored at once; takes effect once run enable clears
            clk_stop_r <= (wd & CLK_STOP_RW_MASK) | (CLK_STOP_RST & ~CLK_STOP_RW_MASK); // R19
         end
      end
   end

   // ----------------------------------------------------------------
   // interrupt status, mask and output
   // ----------------------------------------------------------------
   always_comb
   begin
      irq_status_nxt = irq_status_r;
      if (hit(aph_r, IDX_IRQ_STATUS))
      begin
         irq_status_nxt = irq_status_nxt & ~wd[IRQ_W-1:0];
      end
      // events set after the clear so a set wins
      if (ovf)
      begin
         irq_status_nxt[EVT_OVERFLOW] = 1'b1;
      end
      if (cnt_wr_bad)
      begin
         irq_status_nxt[EVT_REFUSED] = 1'b1;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         irq_status_r <= '0;
         irq_mask_r   <= '0;
         irq_r        <= 1'b0;
      end
      else if (clk_en)
      begin
         irq_status_r <= irq_status_nxt;
         if (hit(aph_r, IDX_IRQ_MASK))
         begin
            irq_mask_r <= wd[IRQ_W-1:0];
         end
         irq_r <= |(irq_status_nxt & (hit(aph_r, IDX_IRQ_MASK) ? wd[IRQ_W-1:0]
                                                                : irq_mask_r));
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign hrdata         = hrdata_r;
   assign hreadyout      = hreadyout_r;
   assign hresp          = HRESP_OKAY;
   assign chip_reset_req = chip_reset_r;
   assign irq            = irq_r;

endmodule

`default_nettype wire

/* testbench/gwt_watchdog_chk.sv */
/* gwt_watchdog_chk: port checks of the guarded watchdog.
   assumes: bound into gwt_watchdog; one clock domain, ref_clk. */
`timescale 1ns/1ps
`default_nettype none
module gwt_watchdog_chk
   import gwt_pkg::*;
#(
   parameter int unsigned RESET_HOLD = RST_HOLD_CYC  // reset length in cycles
)
(
   input wire logic        ref_clk,
   input wire logic        rst_n,
   input wire logic        clk_en,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        chip_reset_req
);
   // --------
   // helper state
   // --------
   logic        take;    // address phase taken this edge
   logic [10:0] hold_r;  // cycles the reset request has been high
   logic [15:0] idx_r;   // index of the last read taken
   assign take = hsel && htrans == HTRANS_NONSEQ && hready && hreadyout && clk_en;
   // reset request length, cleared whenever the request is low
   always_ff @(posedge ref_clk)
      hold_r <= (!rst_n || !chip_reset_req) ? 11'h000 : hold_r + 11'h001;
   // remember which register a read addressed
   always_ff @(posedge ref_clk)
      idx_r <= !rst_n ? 16'h0000 : (take && !hwrite) ? haddr[17:2] : idx_r;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // --------
   // assertions
   // --------
   hresp_okay_a: assert property (hresp == HRESP_OKAY)
      else $error("response not okay");
   read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   write_nowait_a: assert property (take && hwrite |=> hreadyout)
      else $error("write stalled");
   hold_len_a: assert property ($fell(chip_reset_req) |-> hold_r == RESET_HOLD)
      else $error("reset request length wrong");
   hold_max_a: assert property (hold_r <= RESET_HOLD)
      else $error("reset request too long");
   upper_zero_a: assert property (hrdata[31:8] == 24'h00_0000)
      else $error("upper read bits set");
   inhibit_ones_a: assert property ($rose(hreadyout) && idx_r == IDX_CTRL_STATUS
      |-> (hrdata[7:0] & 8'haa) == 8'haa) else $error("inhibit bit read 0");
   unmapped_zero_a: assert property ($rose(hreadyout) && idx_r == 16'h0200
      |-> hrdata == 32'h0000_0000) else $error("unmapped read not 0");
   fixed_bits_a: assert property ($rose(hreadyout) && idx_r == IDX_PORT_SEL_TWO
      |-> (hrdata[7:0] & 8'hd8) == 8'hd8) else $error("fixed port bits lost");
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
/* tb_top: table of register accesses, then overflow, flag, watch clock
   and pin reset cases. assumes: gwt_pkg compiled first; one slave. */
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import gwt_pkg::*;
;
   // --------
   // signals and access table
   // --------
   typedef struct packed {logic w; logic [15:0] a; logic [7:0] d;} gwt_row_t;
   localparam logic [15:0] CS = IDX_CTRL_STATUS, CT = IDX_COUNTER;
   localparam logic [15:0] PS = IDX_PORT_SEL_TWO, ST = IDX_IRQ_STATUS, MK = IDX_IRQ_MASK;
   localparam gwt_row_t ROWS [30] = '{
      {1'b0, CS, 8'haa}, {1'b0, CT, 8'h00}, {1'b0, PS, 8'hd8},
      {1'b0, IDX_CLK_STOP_TWO, 8'hff}, {1'b0, ST, 8'h00}, {1'b0, MK, 8'h00},
      {1'b0, 16'h0200, 8'h00}, {1'b1, CT, 8'h55}, {1'b0, CT, 8'h00},
      {1'b0, ST, 8'h02}, {1'b1, ST, 8'h02}, {1'b0, ST, 8'h00},
      {1'b1, CS, 8'hc0}, {1'b0, CS, 8'haa}, {1'b1, CS, 8'h40},
      {1'b0, CS, 8'hea}, {1'b1, CS, 8'h44}, {1'b0, CS, 8'hea},
      {1'b1, CT, 8'hfd}, {1'b0, CT, 8'hfd}, {1'b1, CS, 8'h50},
      {1'b0, CS, 8'hfa}, {1'b1, CS, 8'h5c}, {1'b0, CS, 8'hfa},
      {1'b1, PS, 8'h00}, {1'b0, PS, 8'hd8}, {1'b1, MK, 8'h03},
      {1'b0, MK, 8'h03}, {1'b1, CS, 8'h54}, {1'b0, CS, 8'hfe}};
   logic        ref_clk = 1'b0, rst_n = 1'b0, watch_clk = 1'b0;
   logic        hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, chip_reset_req, irq;
   logic [1:0]  htrans = 2'b00;
   logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
   int          errors = 0, n_checks = 0, cyc = 0, n;
   gwt_watchdog #(.SYS_DIVIDER(8), .WATCH_DIVIDER(4), .RESET_HOLD(16)) gwt_watchdog_inst (
      .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1), .watch_clk(watch_clk),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .chip_reset_req(chip_reset_req), .irq(irq));
   always #4 ref_clk = ~ref_clk;
   // cut a hang short
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 4000)
      begin
         errors++;
         end_sim();
      end
   end
   // --------
   // tasks
   // --------
   task automatic end_sim();
      if (errors == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // one single ahb transfer, address phase then data phase
   task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d,
                      output logic [31:0] r);
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      haddr <= {14'h0000, a, 2'b00};
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= 32'(d);
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   // write a register, then check irq once it has settled
   task automatic wr_irq(input logic [15:0] a, input logic [7:0] d, input logic e);
      bus(1'b1, a, d, rd);
      repeat (2) @(posedge ref_clk);
      chk("irq", 32'(irq), 32'(e));
   endtask
   // cycles until the reset request rises, bounded
   task automatic rise(output int c);
      c = 0;
      while (chip_reset_req !== 1'b1 && c < 60)
      begin
         @(posedge ref_clk);
         c++;
      end
   endtask
   // --------
   // main sequence
   // --------
   initial
   begin
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      foreach (ROWS[i])
      begin
         bus(ROWS[i].w, ROWS[i].a, ROWS[i].d, rd);
         if (!ROWS[i].w) chk("table", rd, 32'(ROWS[i].d));
      end
      // counter started at fd overflows after three ticks of 8 cycles
      rise(n);
      chk("overflow time", 32'(n >= 8 && n <= 30), 32'h0000_0001);
      repeat (24) @(posedge ref_clk);
      chk("irq overflow", 32'(irq), 32'h0000_0001);
      bus(1'b0, CS, 8'h00, rd);
      chk("flag set", rd, 32'h0000_00ab);
      wr_irq(MK, 8'h00, 1'b0);
      wr_irq(MK, 8'h01, 1'b1);
      wr_irq(ST, 8'h01, 1'b0);
      // flag write needs bit1 zero, then clears
      bus(1'b1, CS, 8'h10, rd);
      bus(1'b1, CS, 8'h13, rd);
      bus(1'b0, CS, 8'h00, rd);
      chk("flag kept", rd, 32'h0000_00bb);
      bus(1'b1, CS, 8'h10, rd);
      bus(1'b0, CS, 8'h00, rd);
      chk("flag cleared", rd, 32'h0000_00ba);
      // watch clock source: still watch clock means no overflow
      bus(1'b1, PS, 8'h04, rd);
      bus(1'b1, CS, 8'h50, rd);
      bus(1'b1, CT, 8'hff, rd);
      bus(1'b1, CS, 8'h54, rd);
      repeat (50) @(posedge ref_clk);
      chk("watch idle", 32'(chip_reset_req), 32'h0000_0000);
      repeat (4)
      begin
         @(posedge ref_clk) watch_clk <= 1'b1;
         @(posedge ref_clk) watch_clk <= 1'b0;
      end
      rise(n);
      chk("watch overflow", 32'(n <= 12), 32'h0000_0001);
      // pin reset after the internal reset has ended clears the flag
      repeat (24) @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      bus(1'b0, CS, 8'h00, rd);
      chk("pin reset", rd, 32'h0000_00aa);
      end_sim();
   end
endmodule
bind gwt_watchdog gwt_watchdog_chk #(.RESET_HOLD(RESET_HOLD)) gwt_watchdog_chk_inst (
   .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .chip_reset_req(chip_reset_req));
`default_nettype wire
